// >>> jcp_chain_host.sv
// Chain host: shifts IR/DR to one target in a daisy chain with padding
//
// The address-and-strobe port and the address map are this design's own decisions.
`include "jcp_defines.svh"

module jcp_chain_host (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [`JCP_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_r,
  output logic tck_r,
  output logic tms_r,
  output logic tdi_r,
  input wire logic tdo
);
  localparam logic [`JCP_PH_W-1:0] PH_HALF = `JCP_PH_W'(`JCP_TCK_HALF_CYC);
  localparam logic [`JCP_PH_W-1:0] PH_LAST = `JCP_PH_W'(2 * `JCP_TCK_HALF_CYC - 1);

  jcp_pkg::jcp_state_type st_r;
  jcp_pkg::jcp_op_type op_r;
  jcp_pkg::jcp_op_type pend_op_r;
  logic pend_r;
  logic [`JCP_LEN_W-1:0] ir_len_r;
  logic [31:0] ir_val_r;
  logic [`JCP_LEN_W-1:0] dr_len_r;
  logic [31:0] dr_val_r;
  logic [`JCP_PAD_W-1:0] lead_ir_r;
  logic [`JCP_PAD_W-1:0] trail_ir_r;
  logic [`JCP_PAD_W-1:0] lead_dr_r;
  logic [`JCP_PAD_W-1:0] trail_dr_r;
  logic [`JCP_PH_W-1:0] ph_r;
  logic [`JCP_IDX_W-1:0] idx_r;
  logic [31:0] cap_r;
  logic [`JCP_LEN_W-1:0] cap_cnt_r;
  logic push_r;
  logic tdo_s1_r;
  logic tdo_s2_r;

  logic is_ir;
  logic is_dr;
  logic [`JCP_LEN_W-1:0] ir_eff;
  logic [`JCP_LEN_W-1:0] dr_eff;
  logic [`JCP_LEN_W-1:0] tlen;
  logic [`JCP_IDX_W-1:0] lead;
  logic [`JCP_IDX_W-1:0] trail;
  logic [`JCP_IDX_W-1:0] total;
  logic [31:0] src;
  logic [5:0] pre_pat;
  logic [2:0] pre_len;
  logic step;
  logic in_target;
  logic [`JCP_IDX_W-1:0] tgt_idx;
  logic tms_nxt;
  logic tdi_nxt;
  logic start;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [31:0] fifo_out_data;
  logic [31:0] push_data;
  logic [`JCP_CNT_W-1:0] fifo_cnt;
  logic [`JCP_LEN_W-1:0] cap_shift;

  // Lengths clamped to 1..32 so a zero setting cannot make an empty shift
  assign ir_eff = (ir_len_r == '0) ? `JCP_LEN_MIN : (ir_len_r > `JCP_LEN_MAX) ? `JCP_LEN_MAX : ir_len_r;
  assign dr_eff = (dr_len_r == '0) ? `JCP_LEN_MIN : (dr_len_r > `JCP_LEN_MAX) ? `JCP_LEN_MAX : dr_len_r;

  // Frame of the current shift: leading pad, target bits, trailing pad
  assign is_ir = (op_r == jcp_pkg::OP_IR);
  assign is_dr = (op_r == jcp_pkg::OP_DR);
  assign tlen = is_ir ? ir_eff : dr_eff;
  assign lead = `JCP_IDX_W'(is_ir ? lead_ir_r : lead_dr_r);
  assign trail = `JCP_IDX_W'(is_ir ? trail_ir_r : trail_dr_r);
  assign total = `JCP_IDX_W'(lead + `JCP_IDX_W'(tlen) + trail);
  assign src = is_ir ? ir_val_r : dr_val_r;
  assign tgt_idx = `JCP_IDX_W'(idx_r - lead);
  assign in_target = (idx_r >= lead) && (idx_r < `JCP_IDX_W'(lead + `JCP_IDX_W'(tlen)));

  // TMS walk from idle to the shift state, or five ones for a TAP reset; an illegal op code gets the reset walk but then enters ST_SHIFT
  assign pre_pat = is_ir ? `JCP_LEADING_INSTR_PAD_LEN_PAT : is_dr ? `JCP_LEADING_DATA_PAD_LEN_PAT : `JCP_PRE_RST_PAT;
  assign pre_len = is_ir ? `JCP_LEADING_INSTR_PAD_LEN_LEN : is_dr ? `JCP_LEADING_DATA_PAD_LEN_LEN : `JCP_PRE_RST_LEN;

  // Bit to present on the pins at the next falling test clock edge
  always_comb begin
    tms_nxt = 1'b0;
    tdi_nxt = 1'b0;
    unique case (st_r)
      jcp_pkg::ST_IDLE: tms_nxt = 1'b0;
      jcp_pkg::ST_PRE: tms_nxt = pre_pat[idx_r[2:0]];
      jcp_pkg::ST_SHIFT: begin
        tms_nxt = (idx_r == `JCP_IDX_W'(total - 1'b1));
        if (in_target) begin
          tdi_nxt = src[tgt_idx[4:0]];
        end else begin
          // Ones put bypassed devices into bypass; DR fillers are zero
          tdi_nxt = is_ir;
        end
      end
      jcp_pkg::ST_POST: tms_nxt = (idx_r == '0);
    endcase
  end

  // Start only with room for a word, counting a push still in flight; a full FIFO stalls the chain
  assign start = (st_r == jcp_pkg::ST_IDLE) && pend_r && fifo_in_ready && !push_r;
  assign step = (st_r != jcp_pkg::ST_IDLE) && (ph_r == PH_LAST);

  // Phase counter paces one test clock period per bit
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ph_r <= '0;
    end else if (st_r == jcp_pkg::ST_IDLE || ph_r == PH_LAST) begin
      ph_r <= '0;
    end else begin
      ph_r <= `JCP_PH_W'(ph_r + 1'b1);
    end
  end

  // Sequencer through preamble, padded shift and return to idle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= jcp_pkg::ST_IDLE;
      idx_r <= '0;
      op_r <= jcp_pkg::OP_IR;
    end else if (start) begin
      st_r <= jcp_pkg::ST_PRE;
      idx_r <= '0;
      op_r <= pend_op_r;
    end else if (step) begin
      unique case (st_r)
        jcp_pkg::ST_PRE: begin
          if (idx_r == `JCP_IDX_W'(pre_len - 1'b1)) begin
            st_r <= (op_r == jcp_pkg::OP_RST) ? jcp_pkg::ST_IDLE : jcp_pkg::ST_SHIFT;
            idx_r <= '0;
          end else begin
            idx_r <= `JCP_IDX_W'(idx_r + 1'b1);
          end
        end
        jcp_pkg::ST_SHIFT: begin
          if (idx_r == `JCP_IDX_W'(total - 1'b1)) begin
            st_r <= jcp_pkg::ST_POST;
            idx_r <= '0;
          end else begin
            idx_r <= `JCP_IDX_W'(idx_r + 1'b1);
          end
        end
        jcp_pkg::ST_POST: begin
          if (idx_r == `JCP_IDX_W'(`JCP_POST_LEN - 1'b1)) begin
            st_r <= jcp_pkg::ST_IDLE;
            idx_r <= '0;
          end else begin
            idx_r <= `JCP_IDX_W'(idx_r + 1'b1);
          end
        end
        default: st_r <= jcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Pins: one clock and one mode select shared by every device
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tck_r <= 1'b0;
      tms_r <= 1'b0;
      tdi_r <= 1'b0;
    end else begin
      tck_r <= (st_r != jcp_pkg::ST_IDLE) && (ph_r >= PH_HALF);
      if (ph_r == '0) begin
        tms_r <= tms_nxt;
        tdi_r <= tdi_nxt;
      end
    end
  end

  // Two-stage synchroniser for the returned serial data
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tdo_s1_r <= 1'b0;
      tdo_s2_r <= 1'b0;
    end else begin
      tdo_s1_r <= tdo;
      tdo_s2_r <= tdo_s1_r;
    end
  end

  // Capture target bits only; leading fillers come out first and are dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap_r <= '0;
      cap_cnt_r <= '0;
    end else if (start) begin
      cap_r <= '0;
      cap_cnt_r <= '0;
    end else if (step && st_r == jcp_pkg::ST_SHIFT && is_dr && in_target) begin
      cap_r <= {tdo_s2_r, cap_r[31:1]};
      cap_cnt_r <= `JCP_LEN_W'(cap_cnt_r + 1'b1);
    end
  end

  // One push per data shift, as the TAP leaves through Update-DR
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      push_r <= 1'b0;
    end else begin
      push_r <= step && is_dr && st_r == jcp_pkg::ST_POST && idx_r == `JCP_IDX_W'(`JCP_POST_LEN - 1'b1);
    end
  end

  // Right-align the captured word, first returned target bit in bit 0
  assign cap_shift = `JCP_LEN_W'(`JCP_WORD_W - dr_eff);
  assign push_data = cap_r >> cap_shift;

  jcp_fifo #(
    .WIDTH(`JCP_WORD_W),
    .DEPTH(`JCP_FIFO_DEPTH),
    .CNT_W(`JCP_CNT_W)
  ) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push_r),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .count(fifo_cnt)
  );
  assign fifo_pop = rd && (addr == `JCP_REG_CAPTURE);

  // Settings; pads are software's sum of bypassed IR lengths or device counts
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ir_len_r <= `JCP_LEN_RST;
      ir_val_r <= '0;
      dr_len_r <= `JCP_LEN_RST;
      dr_val_r <= '0;
      lead_ir_r <= `JCP_PAD_RST;
      trail_ir_r <= `JCP_PAD_RST;
      lead_dr_r <= `JCP_PAD_RST;
      trail_dr_r <= `JCP_PAD_RST;
    end else if (wr) begin
      unique case (addr)
        `JCP_REG_IR_LEN: ir_len_r <= wdata[`JCP_LEN_W-1:0];
        `JCP_REG_IR_VAL: ir_val_r <= wdata;
        `JCP_REG_DR_LEN: dr_len_r <= wdata[`JCP_LEN_W-1:0];
        `JCP_REG_DR_VAL: dr_val_r <= wdata;
        `JCP_REG_LEAD_IR: lead_ir_r <= wdata[`JCP_PAD_W-1:0];
        `JCP_REG_TRAIL_IR: trail_ir_r <= wdata[`JCP_PAD_W-1:0];
        `JCP_REG_LEAD_DR: lead_dr_r <= wdata[`JCP_PAD_W-1:0];
        `JCP_REG_TRAIL_DR: trail_dr_r <= wdata[`JCP_PAD_W-1:0];
        default: ;
      endcase
    end
  end

  // Command latch; a new command wins over the clear at start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_r <= 1'b0;
      pend_op_r <= jcp_pkg::OP_IR;
    end else if (wr && addr == `JCP_REG_CTRL && wdata[2:0] != 3'h0) begin
      pend_r <= 1'b1;
      pend_op_r <= wdata[`JCP_CTRL_RST] ? jcp_pkg::OP_RST :
                   wdata[`JCP_CTRL_IR] ? jcp_pkg::OP_IR : jcp_pkg::OP_DR;
    end else if (start) begin
      pend_r <= 1'b0;
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else if (rd) begin
      unique case (addr)
        `JCP_REG_STATUS: rdata_r <= {25'h0, fifo_cnt, fifo_out_valid, pend_r, st_r != jcp_pkg::ST_IDLE};
        `JCP_REG_IR_LEN: rdata_r <= {26'h0, ir_len_r};
        `JCP_REG_IR_VAL: rdata_r <= ir_val_r;
        `JCP_REG_DR_LEN: rdata_r <= {26'h0, dr_len_r};
        `JCP_REG_DR_VAL: rdata_r <= dr_val_r;
        `JCP_REG_LEAD_IR: rdata_r <= {24'h0, lead_ir_r};
        `JCP_REG_TRAIL_IR: rdata_r <= {24'h0, trail_ir_r};
        `JCP_REG_LEAD_DR: rdata_r <= {24'h0, lead_dr_r};
        `JCP_REG_TRAIL_DR: rdata_r <= {24'h0, trail_dr_r};
        `JCP_REG_CAPTURE: rdata_r <= fifo_out_data;
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // Checks on the shifted stream, test clock, capture pushes and pad reset values
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_IR_LEAD_ONES: assert property (
    (st_r == jcp_pkg::ST_SHIFT && is_ir && ph_r == 4'h1 && idx_r < lead) |-> tdi_r)
    else $error("leading IR pad bit not one");
  AST_IR_TRAIL_ONES: assert property (
    (st_r == jcp_pkg::ST_SHIFT && is_ir && ph_r == 4'h1 && !in_target && idx_r >= lead) |-> tdi_r)
    else $error("trailing IR pad bit not one");
  AST_TARGET_BITS: assert property (
    (st_r == jcp_pkg::ST_SHIFT && ph_r == 4'h1 && in_target) |-> (tdi_r == src[tgt_idx[4:0]]))
    else $error("target bit misplaced");
  AST_DR_FILL_ZERO: assert property (
    (st_r == jcp_pkg::ST_SHIFT && is_dr && ph_r == 4'h1 && !in_target) |-> !tdi_r)
    else $error("data filler not zero");
  AST_EXIT_ON_LAST: assert property (
    (st_r == jcp_pkg::ST_SHIFT && ph_r == 4'h1) |-> (tms_r == (idx_r == `JCP_IDX_W'(total - 1'b1))))
    else $error("TMS leaves shift at wrong bit");
  AST_TCK_HIGH_TIME: assert property ($rose(tck_r) |-> tck_r [*6] ##1 !tck_r)
    else $error("test clock high time wrong");
  AST_CAP_COUNT: assert property (push_r |-> (cap_cnt_r == dr_eff))
    else $error("captured bit count differs from data length");
  AST_PUSH_ONLY_DR: assert property (
    push_r |-> (is_dr && $past(st_r) == jcp_pkg::ST_POST && st_r == jcp_pkg::ST_IDLE))
    else $error("capture pushed outside data shift");
  AST_ZERO_PAD_FIRST: assert property (
    (st_r == jcp_pkg::ST_SHIFT && idx_r == '0 && ph_r == 4'h1 && lead == '0) |-> (tdi_r == src[0]))
    else $error("zero pad did not start with target bit");
  AST_PAD_RESET: assert property (
    $rose(nrst) |-> (lead_ir_r == '0 && trail_ir_r == '0 && lead_dr_r == '0 && trail_dr_r == '0))
    else $error("pad length not zero after reset");
endmodule // jcp_chain_host

// >>> jcp_defines.svh
// Constants for the chain-host padding sequencer: offsets, fields, timing
`ifndef JCP_DEFINES_SVH
`define JCP_DEFINES_SVH

// Clock and test clock timing
`define JCP_CLK_NS 10
`define JCP_TCK_HALF_NS 60
`define JCP_TCK_HALF_CYC ((`JCP_TCK_HALF_NS + `JCP_CLK_NS - 1) / `JCP_CLK_NS)
`define JCP_PH_W 4

// Register byte offsets
`define JCP_ADDR_W 6
`define JCP_REG_CTRL 6'h00
`define JCP_REG_STATUS 6'h04
`define JCP_REG_IR_LEN 6'h08
`define JCP_REG_IR_VAL 6'h0c
`define JCP_REG_DR_LEN 6'h10
`define JCP_REG_DR_VAL 6'h14
`define JCP_REG_LEAD_IR 6'h18
`define JCP_REG_TRAIL_IR 6'h1c
`define JCP_REG_LEAD_DR 6'h20
`define JCP_REG_TRAIL_DR 6'h24
`define JCP_REG_CAPTURE 6'h28

// Control bits
`define JCP_CTRL_IR 0
`define JCP_CTRL_DR 1
`define JCP_CTRL_RST 2

// Field widths and limits
`define JCP_WORD_W 32
`define JCP_LEN_W 6
`define JCP_PAD_W 8
`define JCP_IDX_W 10
`define JCP_LEN_MAX 6'h20
`define JCP_LEN_MIN 6'h01
`define JCP_FIFO_DEPTH 8
`define JCP_CNT_W 4

// Reset values
`define JCP_LEN_RST 6'h01
`define JCP_PAD_RST 8'h00

// TAP walk patterns, TMS sent LSB first
`define JCP_LEADING_INSTR_PAD_LEN_PAT 6'h03
`define JCP_LEADING_INSTR_PAD_LEN_LEN 3'h4
`define JCP_LEADING_DATA_PAD_LEN_PAT 6'h01
`define JCP_LEADING_DATA_PAD_LEN_LEN 3'h3
`define JCP_PRE_RST_PAT 6'h1f
`define JCP_PRE_RST_LEN 3'h6
`define JCP_POST_LEN 10'h002

`endif

// >>> jcp_pkg.sv
// Types for the chain-host padding sequencer
package jcp_pkg;
  // Gray along idle, preamble, shift, postamble
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_PRE = 2'h1,
    ST_SHIFT = 2'h3,
    ST_POST = 2'h2
  } jcp_state_type;

  typedef enum logic [1:0] {
    OP_IR = 2'h0,
    OP_DR = 2'h1,
    OP_RST = 2'h2
  } jcp_op_type;
endpackage

// >>> jcp_fifo.sv
// Capture FIFO of flip-flops with valid/ready on both sides
module jcp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CNT_W-1:0] count
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] rptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic do_push;
  logic do_pop;

  // Honest flags straight from the occupancy count
  assign in_ready = (cnt_r != CNT_W'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign do_push = in_valid && in_ready;
  assign do_pop = out_ready && out_valid;
  assign out_data = out_valid ? mem_r[rptr_r] : '0;
  assign count = cnt_r;

  // Storage, one entry written per push
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // Pointers wrap at depth, which need not be a power of two
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wptr_r <= (wptr_r == PW'(DEPTH - 1)) ? '0 : PW'(wptr_r + 1'b1);
      end
      if (do_pop) begin
        rptr_r <= (rptr_r == PW'(DEPTH - 1)) ? '0 : PW'(rptr_r + 1'b1);
      end
      cnt_r <= CNT_W'(cnt_r + CNT_W'(do_push) - CNT_W'(do_pop));
    end
  end
endmodule // jcp_fifo

// >>> jcp_chain_model.sv
// Behavioural three-device scan chain: input-side bypass device, target, output-side bypass device
module jcp_chain_model #(
  parameter logic [7:0] DR_INIT = 8'ha5
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] st;
  logic [2:0] ir_in;
  logic [3:0] tgt_ir;
  logic [4:0] ir_out;
  logic [7:0] tgt_dr;
  logic [11:0] ir_sh;
  logic [15:0] dr_sh;
  int dlen;

  // Shared TAP walk; DR states from 2, IR states from 9
  function automatic logic [3:0] tap_next(input logic [3:0] s, input logic t);
    logic [3:0] b;
    b = (s >= 4'h9) ? 4'h9 : 4'h2;
    case (s)
      4'h0: return t ? 4'h0 : 4'h1;
      4'h1: return t ? 4'h2 : 4'h1;
      4'h2: return t ? 4'h9 : 4'h3;
      4'h9: return t ? 4'h0 : 4'ha;
      default: case (s - b)
        4'h1, 4'h2: return t ? b + 4'h3 : b + 4'h2;
        4'h3: return t ? b + 4'h6 : b + 4'h4;
        4'h4: return t ? b + 4'h5 : b + 4'h4;
        4'h5: return t ? b + 4'h6 : b + 4'h2;
        default: return t ? 4'h2 : 4'h1;
      endcase
    endcase
  endfunction

  initial begin
    st = 4'h0;
    ir_in = '1;
    tgt_ir = '1;
    ir_out = '1;
    tgt_dr = DR_INIT;
    ir_sh = '0;
    dr_sh = '0;
    tdo = 1'b0;
  end

  // Rising test clock: capture, shift, update; all devices see one mode select
  always @(posedge tck) begin
    dlen = (tgt_ir == 4'hf) ? 3 : 10;
    case (st)
      4'h0: begin
        ir_in = '1;
        tgt_ir = '1;
        ir_out = '1;
      end
      4'h3: dr_sh = (tgt_ir == 4'hf) ? 16'h0000 : {7'h00, tgt_dr, 1'b0};
      4'h4: begin
        dr_sh = dr_sh >> 1;
        dr_sh[dlen-1] = tdi;
      end
      4'h8: if (tgt_ir != 4'hf) tgt_dr = dr_sh[8:1];
      4'ha: ir_sh = 12'h221;
      4'hb: ir_sh = {tdi, ir_sh[11:1]};
      4'hf: begin
        ir_out = ir_sh[4:0];
        tgt_ir = ir_sh[8:5];
        ir_in = ir_sh[11:9];
      end
      default: ;
    endcase
    st = tap_next(st, tms);
  end

  // Output changes on falling edge; outside shifts no stale value is left
  always @(negedge tck) begin
    if (st == 4'h4) tdo <= dr_sh[0];
    else if (st == 4'hb) tdo <= ir_sh[0];
    else tdo <= ~tdo;
  end
endmodule // jcp_chain_model

// >>> jcp_chain_host_tb.sv
// Self-checking bench for the chain host against a three-device chain
`include "jcp_defines.svh"

module jcp_chain_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, wr, rd, tdo, tck_r, tms_r, tdi_r;
  logic [5:0] addr;
  logic [31:0] wdata, rdata_r, rv;
  logic [7:0] dv [0:8];
  int bad_count, comparisons;

  `define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("wrong value at %0t: got %h exp %h", $time, g, e); end end

  jcp_chain_host jcp_chain_host_i (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .tck_r(tck_r), .tms_r(tms_r), .tdi_r(tdi_r), .tdo(tdo));
  // Common test clock and mode select, serial data through the chain
  jcp_chain_model jcp_chain_model_i (.tck(tck_r), .tms(tms_r), .tdi(tdi_r), .tdo(tdo));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata_r;
  endtask

  task automatic stop_test();
    $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Poll until neither busy nor pending; bounded
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    for (n = 0; n < 3000; n++) begin
      rd_reg(`JCP_REG_STATUS, s);
      if (s[1:0] === 2'b00) break;
    end
    if (n == 3000) begin
      bad_count++;
      stop_test();
    end
  endtask

  initial begin
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    comparisons = 0;
    for (int i = 0; i < 9; i++) dv[i] = 8'h3c + 8'(i * 17);
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    // Reset values, write-only and unmapped places
    rd_reg(`JCP_REG_IR_LEN, rv);
    `CHK(rv, 32'h0000_0001)
    for (int a = 8'h18; a <= 8'h24; a += 4) begin
      rd_reg(6'(a), rv);
      `CHK(rv, 32'h0000_0000)
    end
    rd_reg(`JCP_REG_CTRL, rv);
    `CHK(rv, 32'h0000_0000)
    rd_reg(6'h3c, rv);
    `CHK(rv, 32'h0000_0000)
    rd_reg(`JCP_REG_CAPTURE, rv);
    `CHK(rv, 32'h0000_0000)
    // TAP reset walks the chain to idle
    wr_reg(`JCP_REG_CTRL, 32'h0000_0004);
    wait_idle();
    `CHK(jcp_chain_model_i.st, 4'h1)
    // Instruction shift with 5 leading and 3 trailing pad bits
    wr_reg(`JCP_REG_LEAD_IR, 32'h0000_0005);
    wr_reg(`JCP_REG_TRAIL_IR, 32'h0000_0003);
    wr_reg(`JCP_REG_IR_LEN, 32'h0000_0004);
    wr_reg(`JCP_REG_IR_VAL, 32'h0000_0006);
    rd_reg(`JCP_REG_LEAD_IR, rv);
    `CHK(rv, 32'h0000_0005)
    wr_reg(`JCP_REG_CTRL, 32'h0000_0001);
    wait_idle();
    `CHK(jcp_chain_model_i.tgt_ir, 4'h6)
    `CHK(jcp_chain_model_i.ir_out, 5'h1f)
    `CHK(jcp_chain_model_i.ir_in, 3'h7)
    // Data shifts with one filler each side until the capture buffer is full
    wr_reg(`JCP_REG_LEAD_DR, 32'h0000_0001);
    wr_reg(`JCP_REG_TRAIL_DR, 32'h0000_0001);
    wr_reg(`JCP_REG_DR_LEN, 32'h0000_0008);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`JCP_REG_DR_VAL, {24'h0, dv[i]});
      wr_reg(`JCP_REG_CTRL, 32'h0000_0002);
      wait_idle();
      `CHK(jcp_chain_model_i.tgt_dr, dv[i])
    end
    rd_reg(`JCP_REG_STATUS, rv);
    `CHK(rv[6:2], 5'h11)
    // Full buffer holds the next command back
    wr_reg(`JCP_REG_DR_VAL, {24'h0, dv[8]});
    wr_reg(`JCP_REG_CTRL, 32'h0000_0002);
    repeat (400) @(posedge mclk);
    rd_reg(`JCP_REG_STATUS, rv);
    `CHK(rv[1:0], 2'b10)
    `CHK(jcp_chain_model_i.tgt_dr, dv[7])
    // Drain: each word is what the target held before its shift
    for (int i = 0; i < 8; i++) begin
      rd_reg(`JCP_REG_CAPTURE, rv);
      `CHK(rv, {24'h0, (i == 0) ? 8'ha5 : dv[i-1]})
    end
    wait_idle();
    `CHK(jcp_chain_model_i.tgt_dr, dv[8])
    rd_reg(`JCP_REG_CAPTURE, rv);
    `CHK(rv, {24'h0, dv[7]})
    rd_reg(`JCP_REG_CAPTURE, rv);
    `CHK(rv, 32'h0000_0000)
    // Zero pads treat the chain as one device: target bits land one place off
    wr_reg(`JCP_REG_LEAD_DR, 32'h0000_0000);
    wr_reg(`JCP_REG_TRAIL_DR, 32'h0000_0000);
    wr_reg(`JCP_REG_DR_VAL, {24'h0, dv[0]});
    wr_reg(`JCP_REG_CTRL, 32'h0000_0002);
    wait_idle();
    `CHK(jcp_chain_model_i.tgt_dr, {dv[0][6:0], 1'b0})
    rd_reg(`JCP_REG_CAPTURE, rv);
    `CHK(rv, {24'h0, dv[8][6:0], 1'b0})
    // Instruction wins over data when both start bits are set; no word is captured
    wr_reg(`JCP_REG_IR_VAL, 32'h0000_000f);
    wr_reg(`JCP_REG_CTRL, 32'h0000_0003);
    wait_idle();
    `CHK(jcp_chain_model_i.tgt_ir, 4'hf)
    `CHK(jcp_chain_model_i.tgt_dr, {dv[0][6:0], 1'b0})
    rd_reg(`JCP_REG_CAPTURE, rv);
    `CHK(rv, 32'h0000_0000)
    stop_test();
  end
endmodule // jcp_chain_host_tb
